/* verif/isel_host_model.sv */
// Host model: bus master that bit-drives the serial lines.
`timescale 1ns/1ps
`default_nettype none
module isel_host_model
    import isel_pkg::*;
(
    input wire logic clk,
    output logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [AXI_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    logic [31:0] dat;
    logic [1:0] rsp;
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic wr(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            // Late ready makes the answer wait
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [AXI_ADDR_W-1:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            // Late ready makes the data wait
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic lines(input logic c, input logic s);
        wr(PORT_ADDR, {24'h0, c, s, 6'h0}, 4'h1, rsp);
        repeat (3) @(posedge clk);
    endtask : lines
    task automatic cond(input logic st);
        lines(st, st);
        lines(1'b1, 1'b0);
        lines(!st, !st);
    endtask : cond
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                        output logic ack);
        logic [8:0] bits;
        bits = {tx, last};
        for (int i = 8; i >= 0; i--) begin
            lines(1'b0, bits[i]);
            lines(1'b1, bits[i]);
            rd(PORT_ADDR, dat, rsp);
            lines(1'b0, bits[i]);
            if (i > 0) rx[i-1] = dat[SDA_BIT];
        end
        ack = !dat[SDA_BIT];
        lines(1'b0, 1'b1);
    endtask : xfer
endmodule : isel_host_model
`default_nettype wire

/* verif/isel_top_chk_sva.sv */
// Checker of the port register bus at the top ports.
`timescale 1ns/1ps
`default_nettype none
module isel_top_chk
    import isel_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire rd_go = s_axi_arvalid && s_axi_arready;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_b_lat;
        wr_go |-> ##2 s_axi_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    property p_bresp;
        wr_go |-> ##2 s_axi_bresp == (($past(s_axi_awaddr, 2) == PORT_ADDR) ? RESP_OKAY : RESP_SLVERR);
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response code");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken while answering");
    property p_r_lat;
        rd_go |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_rresp;
        rd_go |=> s_axi_rresp == (($past(s_axi_araddr) == PORT_ADDR) ? RESP_OKAY : RESP_SLVERR);
    endproperty
    a_rresp: assert property (p_rresp) else $error("read response code");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_rdata_bits;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[5:0] == 6'h0;
    endproperty
    a_rdata_bits: assert property (p_rdata_bits) else $error("unused read bits set");
    c_wr: cover property (wr_go);
    c_rd: cover property (rd_go);
    c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : isel_top_chk
bind isel_top isel_top_chk isel_top_chk_i (
    .clk(clk), .arst_n(arst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the serial data memory link.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import isel_pkg::*;
();
    localparam int unsigned BUSY_P = 2000;
    localparam logic [7:0] CTRL_W = {DEV_ADDR, 1'b0};
    localparam logic [7:0] CTRL_R = {DEV_ADDR, 1'b1};
    logic clk, arst_n, link_clk, a;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [7:0] b;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    isel_top #(.BUSY_CYCLES_P(BUSY_P)) isel_top_i (
        .clk(clk), .arst_n(arst_n), .link_clk(link_clk),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );
    isel_host_model host (
        .clk(clk),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #3 link_clk = ~link_clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : chk
    task automatic sendc(input string what, input logic [7:0] tx, input logic exp);
        host.xfer(tx, 1'b1, b, a);
        chk(what, 32'(exp), 32'(a));
    endtask : sendc
    task automatic recvc(input string what, input logic [7:0] exp, input logic last);
        host.xfer(8'hff, last, b, a);
        chk(what, 32'(exp), 32'(b));
    endtask : recvc
    task automatic t_reg;
        host.rd(PORT_ADDR, d, r);
        chk("reset lines", 32'hc0, d);
        host.wr(8'h1c, 32'h0, 4'hf, r);
        chk("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
        host.rd(8'h1c, d, r);
        chk("unmapped rdata", 32'h0, d);
        chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
        host.wr(PORT_ADDR, 32'h0, 4'h0, r);
        chk("port bresp", 32'(RESP_OKAY), 32'(r));
        host.rd(PORT_ADDR, d, r);
        host.rd(PORT_ADDR, d, r);
        chk("masked write", 32'hc0, d);
        host.lines(1'b0, 1'b1);
        host.rd(PORT_ADDR, d, r);
        chk("clock low read", 32'h40, d);
        host.lines(1'b1, 1'b1);
        host.rd(PORT_ADDR, d, r);
        chk("clock high read", 32'hc0, d);
    endtask : t_reg
    task automatic t_mem;
        host.cond(1'b1);
        sendc("write ctrl ack", CTRL_W, 1'b1);
        sendc("word addr ack", 8'h05, 1'b1);
        sendc("data ack", 8'ha5, 1'b1);
        sendc("next data ack", 8'h3c, 1'b1);
        host.cond(1'b0);
        host.cond(1'b1);
        sendc("busy nack", CTRL_W, 1'b0);
        host.cond(1'b0);
        repeat (BUSY_P + 100) @(posedge clk);
        host.cond(1'b1);
        sendc("retry ack", CTRL_W, 1'b1);
        sendc("read addr ack", 8'h05, 1'b1);
        host.cond(1'b1);
        sendc("read ctrl ack", CTRL_R, 1'b1);
        recvc("random read", 8'ha5, 1'b1);
        host.cond(1'b0);
        host.cond(1'b1);
        sendc("current ctrl ack", CTRL_R, 1'b1);
        recvc("current read", 8'h3c, 1'b0);
        recvc("sequential read", 8'h00, 1'b1);
        host.cond(1'b0);
        host.cond(1'b1);
        sendc("foreign addr nack", {DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
        host.cond(1'b0);
    endtask : t_mem
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        arst_n = 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_reg();
        t_mem();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire

/* verilog/isel_busy_timer.sv */
// Busy timer started by each toggle of the write-done event.
`timescale 1ns/1ps
`default_nettype none
module isel_busy_timer
    import isel_pkg::*;
#(
    parameter int unsigned CYCLES = BUSY_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic done_tgl,
    output logic busy
);
    typedef struct packed {
        logic prev;
        logic [BUSY_CNT_W-1:0] cnt;
        logic busy;
    } isel_timer_st_t;

    isel_timer_st_t r;
    isel_timer_st_t next_r;

    always_comb begin
        next_r = r;
        next_r.prev = done_tgl;
        // (R11) Busy window load
        if (done_tgl != r.prev) begin
            next_r.cnt = BUSY_CNT_W'(CYCLES);
        end else if (r.cnt != '0) begin
            next_r.cnt = r.cnt - 1'b1;
        end
        next_r.busy = (next_r.cnt != '0);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign busy = r.busy;
endmodule : isel_busy_timer
`default_nettype wire

/* verilog/isel_pkg.sv */
// Constants and types shared by the serial data memory link.
package isel_pkg;

    // Clock rate and busy time after an accepted write
    localparam int unsigned CLK_MHZ = 10;
    localparam int unsigned BUSY_TIME_US = 4000;
    localparam int unsigned BUSY_CYCLES = BUSY_TIME_US * CLK_MHZ;
    localparam int unsigned BUSY_CNT_W = 16;

    // Memory size
    localparam int unsigned MEM_BYTES = 16;
    localparam int unsigned PTR_W = 4;

    // Port register: printed index and byte address
    localparam int unsigned AXI_ADDR_W = 8;
    localparam logic [5:0] PORT_INDEX = 6'h06;
    localparam logic [AXI_ADDR_W-1:0] PORT_ADDR = {PORT_INDEX, 2'h0};
    localparam int unsigned SCL_BIT = 7;
    localparam int unsigned SDA_BIT = 6;
    localparam logic [1:0] LINES_RESET = 2'h3;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Serial protocol
    localparam logic [6:0] DEV_ADDR = 7'h2a;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_TXACK = 5'h10
    } isel_state_t;

    typedef enum logic [2:0] {
        PH_CTRL = 3'h1,
        PH_ADDR = 3'h2,
        PH_DATA = 3'h4
    } isel_phase_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } isel_lines_t;

endpackage : isel_pkg

/* verilog/isel_sync.sv */
// Two flip-flop synchroniser for levels entering a clock domain.
`timescale 1ns/1ps
`default_nettype none
module isel_sync #(
    parameter int W = 2,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } isel_sync_st_t;

    isel_sync_st_t r;
    isel_sync_st_t next_r;

    always_comb begin
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= {RST, RST};
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;
endmodule : isel_sync
`default_nettype wire

/* verilog/isel_top.sv */
// Port register slave and internal two-wire serial data memory.
//
// Overview of operation
// (R1) Sixteen bytes reached only over serial link
// (R2) Data line bit 6, clock bit 7
// (R3) Serial lines stay internal, no pins
// (R4) Data line carries bits both ways
// (R5) Data changes only while clock low
// (R6) Data change with clock high: start/stop
// (R7) Both line bits always act as outputs
// (R8) Data line pulls low only, else released
// (R9) Host writes one before receiving bits
// (R10) Clock push-pull; both lines one after reset
// (R11) Busy after write; accesses then fail
// (R12) Host checks outcome and retries failures
// (R13) Current address read without address phase
// (R14) Host sends address before data or read
// (R15) Port write at end, read at start
// (R16) Host spaces port write and read
// (R17) Port read returns line levels
// (R18) Failure shown by released acknowledge bit
`timescale 1ns/1ps
`default_nettype none
module isel_top
    import isel_pkg::*;
#(
    parameter int unsigned BUSY_CYCLES_P = BUSY_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // Bus side state
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic aw_hit;
        logic w_got;
        logic [7:0] wlow;
        logic wlane;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        isel_lines_t latch;
    } isel_bus_st_t;

    // Link side state
    typedef struct packed {
        isel_state_t st;
        isel_phase_t phase;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic rw;
        logic [PTR_W-1:0] ptr;
        logic [MEM_BYTES-1:0][7:0] mem;
        logic pull;
        logic scl_q;
        logic sda_q;
        logic wrote;
        logic done_tgl;
        isel_lines_t line;
    } isel_link_st_t;

    isel_bus_st_t b;
    isel_bus_st_t next_b;
    isel_link_st_t l;
    isel_link_st_t next_l;

    isel_lines_t host_s;
    isel_lines_t line_s;
    logic busy_c;
    logic busy_s;
    logic done_s;

    function automatic logic is_port(input logic [AXI_ADDR_W-1:0] addr);
        is_port = (addr == PORT_ADDR);
    endfunction : is_port

    // Bus side register and slave logic
    always_comb begin
        next_b = b;
        // Read channel
        if (s_axi_arvalid && b.arready) begin
            next_b.arready = 1'b0;
            next_b.rvalid = 1'b1;
            if (is_port(s_axi_araddr)) begin
                // (R17) Line levels returned
                next_b.rdata = {24'h0, line_s.scl, line_s.sda, 6'h0};
                next_b.rresp = RESP_OKAY;
            end else begin
                next_b.rdata = 32'h0;
                next_b.rresp = RESP_SLVERR;
            end
        end
        if (b.rvalid && s_axi_rready) begin
            next_b.rvalid = 1'b0;
            next_b.arready = 1'b1;
        end
        // Write address and data in either order
        if (s_axi_awvalid && b.awready) begin
            next_b.awready = 1'b0;
            next_b.aw_got = 1'b1;
            next_b.aw_hit = is_port(s_axi_awaddr);
        end
        if (s_axi_wvalid && b.wready) begin
            next_b.wready = 1'b0;
            next_b.w_got = 1'b1;
            next_b.wlow = s_axi_wdata[7:0];
            next_b.wlane = s_axi_wstrb[0];
        end
        if (b.aw_got && b.w_got && !b.bvalid) begin
            next_b.aw_got = 1'b0;
            next_b.w_got = 1'b0;
            next_b.bvalid = 1'b1;
            if (b.aw_hit) begin
                next_b.bresp = RESP_OKAY;
                if (b.wlane) begin
                    // (R2) Line bits in port register
                    next_b.latch.scl = b.wlow[SCL_BIT];
                    // (R15) Latch at end of cycle
                    next_b.latch.sda = b.wlow[SDA_BIT];
                end
            end else begin
                next_b.bresp = RESP_SLVERR;
            end
        end
        if (b.bvalid && s_axi_bready) begin
            next_b.bvalid = 1'b0;
            next_b.awready = 1'b1;
            next_b.wready = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            b <= '0;
            b.awready <= 1'b1;
            b.wready <= 1'b1;
            b.arready <= 1'b1;
            // (R10) Both lines one after reset
            b.latch <= LINES_RESET;
        end else begin
            b <= next_b;
        end
    end

    // Port latch into link domain
    isel_sync #(
        .W(2),
        .RST(LINES_RESET)
    ) u_host_sync (
        .clk(link_clk),
        .arst_n(arst_n),
        .d(b.latch),
        .q(host_s)
    );

    // Busy level into link domain
    isel_sync #(
        .W(1),
        .RST(1'b0)
    ) u_busy_sync (
        .clk(link_clk),
        .arst_n(arst_n),
        .d(busy_c),
        .q(busy_s)
    );

    // Line levels back to bus domain
    isel_sync #(
        .W(2),
        .RST(LINES_RESET)
    ) u_line_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d(l.line),
        .q(line_s)
    );

    // Write-done event back to bus domain
    isel_sync #(
        .W(1),
        .RST(1'b0)
    ) u_done_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d(l.done_tgl),
        .q(done_s)
    );

    isel_busy_timer #(
        .CYCLES(BUSY_CYCLES_P)
    ) u_busy (
        .clk(clk),
        .arst_n(arst_n),
        .done_tgl(done_s),
        .busy(busy_c)
    );

    // Serial memory on the link clock
    always_comb begin
        logic scl_now;
        logic sda_now;
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic ok;
        logic [7:0] byte_c;
        next_l = l;
        // (R7) Clock always driven by the latch
        scl_now = host_s.scl;
        // (R8) Open drain, pull-up when released
        sda_now = host_s.sda & ~l.pull;
        scl_rise = scl_now & ~l.scl_q;
        scl_fall = ~scl_now & l.scl_q;
        // (R6) Start and stop detection
        start_c = scl_now & l.scl_q & l.sda_q & ~sda_now;
        stop_c = scl_now & l.scl_q & ~l.sda_q & sda_now;
        ok = 1'b0;
        byte_c = l.mem[l.ptr];
        next_l.scl_q = scl_now;
        next_l.sda_q = sda_now;
        next_l.line.scl = scl_now;
        next_l.line.sda = sda_now;
        if (start_c || stop_c) begin
            // (R11) Accepted write starts busy time
            if (l.wrote) begin
                next_l.done_tgl = ~l.done_tgl;
                next_l.wrote = 1'b0;
            end
            next_l.pull = 1'b0;
            next_l.bitcnt = 4'h0;
            next_l.phase = PH_CTRL;
            next_l.st = start_c ? ST_RX : ST_IDLE;
        end else begin
            case (l.st)
                ST_IDLE: begin
                    next_l.pull = 1'b0;
                end
                ST_RX: begin
                    // (R5) Sample on clock rise
                    if (scl_rise && l.bitcnt != BITS_PER_BYTE) begin
                        next_l.shreg = {l.shreg[6:0], sda_now};
                        next_l.bitcnt = l.bitcnt + 4'h1;
                    end
                    if (scl_fall && l.bitcnt == BITS_PER_BYTE) begin
                        case (l.phase)
                            PH_CTRL: begin
                                // (R11) Refuse access while busy
                                ok = !busy_s && l.shreg[7:1] == DEV_ADDR;
                                next_l.rw = l.shreg[0];
                            end
                            PH_ADDR: begin
                                ok = 1'b1;
                                next_l.ptr = l.shreg[PTR_W-1:0];
                            end
                            PH_DATA: begin
                                ok = 1'b1;
                                // (R1) Byte stored in local memory
                                next_l.mem[l.ptr] = l.shreg;
                                next_l.ptr = l.ptr + 4'h1;
                                next_l.wrote = 1'b1;
                            end
                            default: begin
                                ok = 1'b0;
                            end
                        endcase
                        // (R18) Nack leaves line released
                        next_l.pull = ok;
                        next_l.st = ok ? ST_ACK : ST_IDLE;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        next_l.bitcnt = 4'h0;
                        next_l.pull = 1'b0;
                        if (l.phase == PH_CTRL && l.rw) begin
                            // (R13) Read from current address
                            // (R4) Memory drives data out
                            next_l.pull = ~byte_c[7];
                            next_l.shreg = {byte_c[6:0], 1'b0};
                            next_l.ptr = l.ptr + 4'h1;
                            next_l.bitcnt = 4'h1;
                            next_l.st = ST_TX;
                        end else begin
                            next_l.phase = (l.phase == PH_CTRL) ? PH_ADDR : PH_DATA;
                            next_l.st = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    // (R5) Drive changes on clock fall
                    if (scl_fall) begin
                        if (l.bitcnt == BITS_PER_BYTE) begin
                            next_l.pull = 1'b0;
                            next_l.st = ST_TXACK;
                        end else begin
                            next_l.pull = ~l.shreg[7];
                            next_l.shreg = {l.shreg[6:0], 1'b0};
                            next_l.bitcnt = l.bitcnt + 4'h1;
                        end
                    end
                end
                ST_TXACK: begin
                    if (scl_rise) begin
                        next_l.st = sda_now ? ST_IDLE : ST_ACK;
                    end
                end
                default: begin
                    next_l.st = ST_IDLE;
                    next_l.pull = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            l <= '0;
            l.st <= ST_IDLE;
            l.phase <= PH_CTRL;
            l.scl_q <= 1'b1;
            l.sda_q <= 1'b1;
            l.line <= LINES_RESET;
        end else begin
            l <= next_l;
        end
    end

    // (R3) Lines reach only the memory and the port read
    assign s_axi_awready = b.awready;
    assign s_axi_wready = b.wready;
    assign s_axi_bresp = b.bresp;
    assign s_axi_bvalid = b.bvalid;
    assign s_axi_arready = b.arready;
    assign s_axi_rdata = b.rdata;
    assign s_axi_rresp = b.rresp;
    assign s_axi_rvalid = b.rvalid;

endmodule : isel_top
`default_nettype wire
